// ---- design/sub_datapath.sv ----
// apb-reached execution core for the two subtract instructions
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module sub_datapath #(
  parameter int MEM_DEPTH = 4096
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  logic [7:0] acc_q;
  logic [4:0] status_q;
  logic ext_q;
  logic [3:0] bank_q;
  logic [11:0] index_q;
  logic [11:0] mem_addr_q;
  logic [7:0] mem_q [MEM_DEPTH];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ==========================================================
  // apb decode
  wire setup_w = psel && !penable;
  wire access_w = psel && penable && pready_q;
  wire wr_w = access_w && pwrite;
  wire sel_acc = (paddr == sub_pkg::OFS_ACC);
  wire sel_status = (paddr == sub_pkg::OFS_STATUS);
  wire sel_ctrl = (paddr == sub_pkg::OFS_CTRL);
  wire sel_instr = (paddr == sub_pkg::OFS_INSTR);
  wire sel_maddr = (paddr == sub_pkg::OFS_MEM_ADDR);
  wire sel_mdata = (paddr == sub_pkg::OFS_MEM_DATA);
  wire sel_bank = (paddr == sub_pkg::OFS_BANK);
  wire sel_index = (paddr == sub_pkg::OFS_INDEX);
  wire mapped_w = sel_acc | sel_status | sel_ctrl | sel_instr | sel_maddr | sel_mdata |
                  sel_bank | sel_index;

  // ==========================================================
  // instruction decode and operand addressing
  wire [15:0] ins_w = pwdata[15:0];
  wire is_lit_w = (ins_w[15:8] == sub_pkg::OPC_LIT);
  wire is_reg_w = (ins_w[15:10] == sub_pkg::OPC_REG);
  wire dest_w = ins_w[sub_pkg::INS_DEST];
  wire bsel_w = ins_w[sub_pkg::INS_BSEL];
  wire [7:0] f_w = ins_w[7:0];
  wire exec_w = wr_w && sel_instr && (is_lit_w || is_reg_w);
  wire exec_lit_w = exec_w && is_lit_w;
  wire exec_reg_w = exec_w && is_reg_w;
  wire indexed_w = !bsel_w && ext_q && (f_w <= sub_pkg::IDX_LIMIT);
  wire [11:0] idx_addr_w = index_q + {4'h0, f_w};
  wire [11:0] access_addr_w = (f_w <= sub_pkg::IDX_LIMIT) ? {sub_pkg::BANK_LOW, f_w}
                                                           : {sub_pkg::BANK_HIGH, f_w};
  wire [11:0] op_addr_w = indexed_w ? idx_addr_w : (bsel_w ? {bank_q, f_w} : access_addr_w);
  wire [7:0] op_data_w = mem_q[op_addr_w];
  wire [7:0] mem_rd_w = mem_q[mem_addr_q];

  // ==========================================================
  // subtractor
  alu_if alu_bus ();
  sub_alu u_alu (
    .io(alu_bus.alu)
  );
  assign alu_bus.minuend = is_lit_w ? f_w : op_data_w;
  assign alu_bus.subtrahend = acc_q;
  wire [7:0] diff_w = alu_bus.diff;
  wire [4:0] flags_w = alu_bus.flags;
  // destination into the accumulator
  wire acc_take_w = exec_lit_w || (exec_reg_w && !dest_w);

  // ==========================================================
  // read mux, set up one cycle before the access phase
  wire [31:0] rd_mux_w = sel_acc ? {24'h0, acc_q} :
                         sel_status ? {27'h0, status_q} :
                         sel_ctrl ? {31'h0, ext_q} :
                         sel_maddr ? {20'h0, mem_addr_q} :
                         sel_mdata ? {24'h0, mem_rd_w} :
                         sel_bank ? {28'h0, bank_q} :
                         sel_index ? {20'h0, index_q} : 32'h0;

  // one wait-free access phase: pready rises in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup_w;
      pslverr_q <= setup_w && !mapped_w;
      prdata_q <= (setup_w && !pwrite) ? rd_mux_w : 32'h0;
    end
  end

  // ==========================================================
  // architectural state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= sub_pkg::RST_ACC;
    end else if (acc_take_w) begin
      acc_q <= diff_w;
    end else if (wr_w && sel_acc) begin
      acc_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= sub_pkg::RST_STATUS;
    end else if (exec_w) begin
      status_q <= flags_w;
    end else if (wr_w && sel_status) begin
      status_q <= pwdata[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= sub_pkg::RST_EXT;
      bank_q <= sub_pkg::RST_BANK;
      index_q <= sub_pkg::RST_INDEX;
      mem_addr_q <= sub_pkg::RST_MEM_ADDR;
    end else if (wr_w) begin
      if (sel_ctrl) ext_q <= pwdata[sub_pkg::CTRL_EXT];
      if (sel_bank) bank_q <= pwdata[3:0];
      if (sel_index) index_q <= pwdata[11:0];
      if (sel_maddr) mem_addr_q <= pwdata[11:0];
    end
  end

  // data memory is plain storage, so it carries no reset
  always_ff @(posedge pclk) begin
    if (exec_reg_w && dest_w) begin
      mem_q[op_addr_w] <= diff_w;
    end else if (wr_w && sel_mdata) begin
      mem_q[mem_addr_q] <= pwdata[7:0];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================
  // checks
  wire [7:0] lit_exp_w = f_w - acc_q;
  wire [7:0] reg_exp_w = op_data_w - acc_q;
  wire neg_w = is_reg_w ? (op_data_w < acc_q) : (f_w < acc_q);
  wire [7:0] min_w = is_reg_w ? op_data_w : f_w;
  wire [7:0] dif_w = min_w - acc_q;
  // signed wrap: operands of unlike sign and result sign unlike the minuend
  wire wrap_exp_w = (min_w[7] != acc_q[7]) && (dif_w[7] != min_w[7]);
  wire half_exp_w = (min_w[3:0] >= acc_q[3:0]);

  property p_lit_result;
    @(posedge pclk) disable iff (!presetn)
      exec_lit_w |=> acc_q == $past(lit_exp_w);
  endproperty
  a_lit_result: assert property (p_lit_result) else $error("literal subtract wrong");

  property p_reg_diff;
    @(posedge pclk) disable iff (!presetn)
      exec_reg_w && !dest_w |=> acc_q == $past(reg_exp_w);
  endproperty
  a_reg_diff: assert property (p_reg_diff) else $error("register subtract wrong");

  property p_dest_acc;
    @(posedge pclk) disable iff (!presetn)
      exec_reg_w && !dest_w |=> mem_q[$past(op_addr_w)] == $past(op_data_w);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("operand changed");

  property p_dest_reg;
    @(posedge pclk) disable iff (!presetn)
      exec_reg_w && dest_w |=> mem_q[$past(op_addr_w)] == $past(reg_exp_w) && $stable(acc_q);
  endproperty
  a_dest_reg: assert property (p_dest_reg) else $error("write back wrong");

  property p_indexed;
    @(posedge pclk) disable iff (!presetn)
      exec_reg_w && dest_w && indexed_w |=> mem_q[$past(idx_addr_w)] == $past(reg_exp_w);
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_borrow;
    @(posedge pclk) disable iff (!presetn)
      exec_w && neg_w |=> !status_q[sub_pkg::ST_BORROW];
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow bit not cleared");

  property p_flags;
    @(posedge pclk) disable iff (!presetn)
      exec_lit_w |=> status_q[sub_pkg::ST_NULL] == (acc_q == 8'h00) &&
                     status_q[sub_pkg::ST_MSB] == acc_q[7];
  endproperty
  a_flags: assert property (p_flags) else $error("zero or msb flag wrong");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      exec_w |=> status_q[sub_pkg::ST_WRAP] == $past(wrap_exp_w);
  endproperty
  a_wrap: assert property (p_wrap) else $error("signed wrap bit wrong");

  property p_half;
    @(posedge pclk) disable iff (!presetn)
      exec_w |=> status_q[sub_pkg::ST_HALF] == $past(half_exp_w);
  endproperty
  a_half: assert property (p_half) else $error("half borrow bit wrong");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      setup_w |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready timing wrong");

  // an unmapped offset is refused with an error and reads as zero
  property p_slverr;
    @(posedge pclk) disable iff (!presetn)
      setup_w && !mapped_w |=> pslverr && (prdata == 32'h0);
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");

endmodule

// ---- design/sub_pkg.sv ----
// constants for the subtract datapath and its apb register map
package sub_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_ACC = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_INSTR = 8'h0c;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h10;
  localparam logic [7:0] OFS_MEM_DATA = 8'h14;
  localparam logic [7:0] OFS_BANK = 8'h18;
  localparam logic [7:0] OFS_INDEX = 8'h1c;

  // ==========================================================
  // status and control field positions
  localparam int ST_BORROW = 0;
  localparam int ST_HALF = 1;
  localparam int ST_NULL = 2;
  localparam int ST_WRAP = 3;
  localparam int ST_MSB = 4;
  localparam int ST_W = 5;
  localparam int CTRL_EXT = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [4:0] RST_STATUS = 5'h00;
  localparam logic RST_EXT = 1'b0;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_INDEX = 12'h000;
  localparam logic [11:0] RST_MEM_ADDR = 12'h000;

  // ==========================================================
  // instruction encoding
  localparam logic [7:0] OPC_LIT = 8'h08;
  localparam logic [5:0] OPC_REG = 6'h17;
  localparam int INS_DEST = 9;
  localparam int INS_BSEL = 8;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [3:0] BANK_LOW = 4'h0;
  localparam logic [3:0] BANK_HIGH = 4'hf;

endpackage

// ---- design/alu_if.sv ----
// operand and result bundle between the core and its subtractor
`timescale 1ns/1ps
interface alu_if;
  logic [7:0] minuend;
  logic [7:0] subtrahend;
  logic [7:0] diff;
  logic [4:0] flags;

  modport core (output minuend, output subtrahend, input diff, input flags);
  modport alu (input minuend, input subtrahend, output diff, output flags);
endinterface

// ---- design/sub_alu.sv ----
// eight-bit subtractor with status flag generation
`timescale 1ns/1ps
module sub_alu (
  alu_if.alu io
);
  logic [8:0] full_w;
  logic [4:0] low_w;
  logic [7:0] d_w;

  // ==========================================================
  // two's complement difference
  // two's complement subtract
  assign full_w = {1'b0, io.minuend} - {1'b0, io.subtrahend};
  assign low_w = {1'b0, io.minuend[3:0]} - {1'b0, io.subtrahend[3:0]};
  assign d_w = full_w[7:0];
  assign io.diff = d_w;

  assign io.flags[sub_pkg::ST_BORROW] = ~full_w[8];
  assign io.flags[sub_pkg::ST_HALF] = ~low_w[4];
  assign io.flags[sub_pkg::ST_NULL] = (d_w == 8'h00);
  assign io.flags[sub_pkg::ST_WRAP] = (io.minuend[7] != io.subtrahend[7]) &&
                                      (d_w[7] != io.minuend[7]);
  assign io.flags[sub_pkg::ST_MSB] = d_w[7];
endmodule

// ---- test/test_subtract_instruction_datapath.sv ----
// self-checking bench for the apb-reached subtract datapath
`timescale 1ns/1ps
module test_subtract_instruction_datapath;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic slv;
  logic [7:0] paddr;
  logic [7:0] rnd;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  int num_errors;
  int n_compared;

  sub_datapath sub_datapath_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================
  // expectation helpers
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // borrow and half borrow read 1 when no borrow happened
  function automatic logic [31:0] flg(input logic [7:0] m, input logic [7:0] s);
    logic [7:0] d;
    d = m - s;
    flg = 32'h0;
    flg[sub_pkg::ST_BORROW] = m >= s;
    flg[sub_pkg::ST_HALF] = m[3:0] >= s[3:0];
    flg[sub_pkg::ST_NULL] = d == 8'h00;
    flg[sub_pkg::ST_WRAP] = (m[7] != s[7]) && (d[7] != m[7]);
    flg[sub_pkg::ST_MSB] = d[7];
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lit_op(input logic [7:0] k, input logic [7:0] w);
    apb(1'b1, sub_pkg::OFS_ACC, {24'h0, w});
    apb(1'b1, sub_pkg::OFS_INSTR, {16'h0, sub_pkg::OPC_LIT, k});
    apb(1'b0, sub_pkg::OFS_ACC, 32'h0);
    chk(rd, {24'h0, k - w});
    chk({31'h0, slv}, 32'h0);
    apb(1'b0, sub_pkg::OFS_STATUS, 32'h0);
    chk(rd, flg(k, w));
  endtask

  // operand byte v placed at data address ma, accumulator w
  task automatic reg_op(input logic [11:0] ma, input logic [7:0] f, input logic dst,
                        input logic asel, input logic [7:0] v, input logic [7:0] w);
    apb(1'b1, sub_pkg::OFS_MEM_ADDR, {20'h0, ma});
    apb(1'b1, sub_pkg::OFS_MEM_DATA, {24'h0, v});
    apb(1'b1, sub_pkg::OFS_ACC, {24'h0, w});
    apb(1'b1, sub_pkg::OFS_INSTR, {16'h0, sub_pkg::OPC_REG, dst, asel, f});
    apb(1'b0, sub_pkg::OFS_ACC, 32'h0);
    chk(rd, {24'h0, dst ? w : v - w});
    apb(1'b0, sub_pkg::OFS_MEM_DATA, 32'h0);
    chk(rd, {24'h0, dst ? v - w : v});
    apb(1'b0, sub_pkg::OFS_STATUS, 32'h0);
    chk(rd, flg(v, w));
  endtask

  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the whole run needs a little over a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    complete_run;
  end

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rnd = 8'h48;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sub_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, slv}, 32'h1);
    chk(rd, 32'h0);
    $display("reset test done");
    lit_op(8'h02, 8'h01);
    lit_op(8'h02, 8'h02);
    lit_op(8'h02, 8'h03);
    lit_op(8'h80, 8'h01);
    lit_op(8'h7f, 8'hff);
    lit_op(8'h10, 8'h01);
    lit_op(8'hff, 8'h00);
    repeat (30) begin
      lit_op(rnd, lfsr(rnd));
      rnd = lfsr(lfsr(rnd));
    end
    $display("literal test done");
    apb(1'b1, sub_pkg::OFS_BANK, 32'h3);
    reg_op(12'h3a5, 8'ha5, 1'b0, 1'b1, 8'h03, 8'h02);
    reg_op(12'h3a5, 8'ha5, 1'b1, 1'b1, 8'h01, 8'h02);
    repeat (20) begin
      reg_op({4'h3, rnd}, rnd, rnd[0], 1'b1, lfsr(rnd), rnd ^ 8'h5c);
      rnd = lfsr(rnd);
    end
    reg_op(12'h05f, 8'h5f, 1'b0, 1'b0, 8'h40, 8'h41);
    reg_op(12'hf60, 8'h60, 1'b1, 1'b0, 8'h90, 8'h11);
    // indexed mode, base chosen so base plus 5fh wraps
    apb(1'b1, sub_pkg::OFS_CTRL, 32'h1);
    apb(1'b1, sub_pkg::OFS_INDEX, 32'hffa);
    reg_op(12'h059, 8'h5f, 1'b0, 1'b0, 8'h22, 8'h33);
    reg_op(12'hffa, 8'h00, 1'b1, 1'b0, 8'h08, 8'h09);
    reg_op(12'hf60, 8'h60, 1'b0, 1'b0, 8'h7e, 8'h81);
    reg_op(12'h310, 8'h10, 1'b1, 1'b1, 8'hc4, 8'h4c);
    $display("register test done");
    complete_run;
  end
endmodule
